// >>> rtl/cpr_ctrl_bank.sv
// Control and status register bank for a pair of analog comparators
// Notes on behaviour
// - One 32-bit word at 0x1c, resets zero
// - Control fields writable unless their lane frozen
// - Bit 0 drives comparator A enable
// - Bit 1 closes A plus-to-converter switch
// - Bits 3:2 pick A speed/power mode
// - Bits 6:4 pick A minus input source
// - Bits 10:8 route A output to timers
// - Bit 11 inverts A output polarity
// - Bits 13:12 set A hysteresis level
// - Bit 14 reads A level after polarity
// - Bit 15 A freeze, set once, reset clears
// - Frozen A ignores writes, keeps reading back
// - Bit 16 drives comparator B enable
// - Bits 19:18 pick B speed/power mode
// - Bits 22:20 pick B minus input source
// - Bit 23 joins pair as window comparator
// - Bits 26:24 route B output to timers
// - Window ties plus inputs, drops B pin
// - Bit 27 inverts B output polarity
// - Bits 29:28 set B hysteresis level
// - Bit 31 B freeze, makes B read-only
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "cpr_params.svh"
module cpr_ctrl_bank
  import cpr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // Peripheral clock, 125 MHz
  input wire logic nrst, // System reset, active low, asynchronous
  input wire logic clk_en, // Freezes all state but the reset release while low
  input wire logic [ADDR_W-1:0] reg_addr, // Byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic cmp_a_raw, // Raw comparator A output
  input wire logic cmp_b_raw, // Raw comparator B output
  output logic cmp_a_enable, // Comparator A on
  output logic cmp_a_dac_switch, // A plus input to converter pin
  output cpr_speed_t cmp_a_speed_power, // A speed/power mode
  output cpr_msel_t cmp_a_minus_select, // A minus input source
  output cpr_route_t cmp_a_route, // A output route
  output logic cmp_a_polarity_flip, // A polarity flip
  output cpr_hyst_t cmp_a_hysteresis, // A hysteresis
  output logic cmp_a_freeze, // A fields locked
  output logic cmp_a_level, // A level after polarity
  output logic [6:0] cmp_a_dest, // A level on its timer input
  output logic cmp_b_enable, // Comparator B on
  output cpr_speed_t cmp_b_speed_power, // B speed/power mode
  output cpr_msel_t cmp_b_minus_select, // B minus input source
  output cpr_route_t cmp_b_route, // B output route
  output logic cmp_b_polarity_flip, // B polarity flip
  output cpr_hyst_t cmp_b_hysteresis, // B hysteresis
  output logic cmp_b_freeze, // B fields locked
  output logic cmp_b_level, // B level after polarity
  output logic [6:0] cmp_b_dest, // B level on its timer input
  output logic window_pair_enable, // Window mode
  output logic plus_inputs_tied, // A and B plus inputs joined
  output logic cmp_b_pin_connect // B plus input on its own pin
);
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
    $error("cpr_ctrl_bank: ADDR_W must lie in 5..32");
  end

  logic [1:0] rst_pipe_q;
  logic rst_n_q;
  logic hit;
  logic wr_hit;
  logic [1:0] lvl_sync;
  logic a_lvl_q;
  logic b_lvl_q;
  logic [31:0] csts_word;
  logic [31:0] rdata_q;
  logic [6:0] a_dest_q;
  logic [6:0] b_dest_q;

  // Reset release only; kept free of clk_en so reset always ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_pipe_q[1];

  assign hit = (reg_addr == ADDR_W'(`CPR_CSTS_OFF));
  assign wr_hit = reg_wr && hit;

  cpr_lane u_lane_a (
    .clk(clk),
    .rst_n(rst_n_q),
    .clk_en(clk_en),
    .wr_hit(wr_hit),
    .en_in(reg_wdata[`CPR_A_EN]),
    .aux_in(reg_wdata[`CPR_A_SW]),
    .spd_in(cpr_speed_t'(reg_wdata[`CPR_A_SPD +: 2])),
    .msel_in(cpr_msel_t'(reg_wdata[`CPR_A_MSEL +: 3])),
    .route_in(cpr_route_t'(reg_wdata[`CPR_A_ROUTE +: 3])),
    .flip_in(reg_wdata[`CPR_A_FLIP]),
    .hys_in(cpr_hyst_t'(reg_wdata[`CPR_A_HYS +: 2])),
    .frz_in(reg_wdata[`CPR_A_FRZ]),
    .en_q(cmp_a_enable),
    .aux_q(cmp_a_dac_switch),
    .spd_q(cmp_a_speed_power),
    .msel_q(cmp_a_minus_select),
    .route_q(cmp_a_route),
    .flip_q(cmp_a_polarity_flip),
    .hys_q(cmp_a_hysteresis),
    .frz_q(cmp_a_freeze)
  );

  // Window enable belongs to the B lane, so the B freeze guards it too
  cpr_lane u_lane_b (
    .clk(clk),
    .rst_n(rst_n_q),
    .clk_en(clk_en),
    .wr_hit(wr_hit),
    .en_in(reg_wdata[`CPR_B_EN]),
    .aux_in(reg_wdata[`CPR_B_WIN]),
    .spd_in(cpr_speed_t'(reg_wdata[`CPR_B_SPD +: 2])),
    .msel_in(cpr_msel_t'(reg_wdata[`CPR_B_MSEL +: 3])),
    .route_in(cpr_route_t'(reg_wdata[`CPR_B_ROUTE +: 3])),
    .flip_in(reg_wdata[`CPR_B_FLIP]),
    .hys_in(cpr_hyst_t'(reg_wdata[`CPR_B_HYS +: 2])),
    .frz_in(reg_wdata[`CPR_B_FRZ]),
    .en_q(cmp_b_enable),
    .aux_q(window_pair_enable),
    .spd_q(cmp_b_speed_power),
    .msel_q(cmp_b_minus_select),
    .route_q(cmp_b_route),
    .flip_q(cmp_b_polarity_flip),
    .hys_q(cmp_b_hysteresis),
    .frz_q(cmp_b_freeze)
  );

  assign plus_inputs_tied = window_pair_enable;
  assign cmp_b_pin_connect = !window_pair_enable;

  cpr_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n_q),
    .clk_en(clk_en),
    .d({cmp_b_raw, cmp_a_raw}),
    .q(lvl_sync)
  );

  // Polarity applied after the synchroniser so a flip takes one cycle
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      a_lvl_q <= 1'b0;
      b_lvl_q <= 1'b0;
    end else if (clk_en) begin
      a_lvl_q <= lvl_sync[0] ^ cmp_a_polarity_flip;
      b_lvl_q <= lvl_sync[1] ^ cmp_b_polarity_flip;
    end
  end
  assign cmp_a_level = a_lvl_q;
  assign cmp_b_level = b_lvl_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      a_dest_q <= 7'h00;
      b_dest_q <= 7'h00;
    end else if (clk_en) begin
      a_dest_q <= cpr_route_onehot(cmp_a_route) & {7{a_lvl_q}};
      b_dest_q <= cpr_route_onehot(cmp_b_route) & {7{b_lvl_q}};
    end
  end
  assign cmp_a_dest = a_dest_q;
  assign cmp_b_dest = b_dest_q;

  // B level stays off the word; bit 30 reads zero like the reserved bits
  always_comb begin
    csts_word = `CPR_CSTS_RST;
    csts_word[`CPR_A_EN] = cmp_a_enable;
    csts_word[`CPR_A_SW] = cmp_a_dac_switch;
    csts_word[`CPR_A_SPD +: 2] = cmp_a_speed_power;
    csts_word[`CPR_A_MSEL +: 3] = cmp_a_minus_select;
    csts_word[`CPR_A_ROUTE +: 3] = cmp_a_route;
    csts_word[`CPR_A_FLIP] = cmp_a_polarity_flip;
    csts_word[`CPR_A_HYS +: 2] = cmp_a_hysteresis;
    csts_word[`CPR_A_LVL] = a_lvl_q;
    csts_word[`CPR_A_FRZ] = cmp_a_freeze;
    csts_word[`CPR_B_EN] = cmp_b_enable;
    csts_word[`CPR_B_SPD +: 2] = cmp_b_speed_power;
    csts_word[`CPR_B_MSEL +: 3] = cmp_b_minus_select;
    csts_word[`CPR_B_WIN] = window_pair_enable;
    csts_word[`CPR_B_ROUTE +: 3] = cmp_b_route;
    csts_word[`CPR_B_FLIP] = cmp_b_polarity_flip;
    csts_word[`CPR_B_HYS +: 2] = cmp_b_hysteresis;
    csts_word[`CPR_B_FRZ] = cmp_b_freeze;
  end

  // Data stands one cycle only; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_q <= (reg_rd && hit) ? csts_word : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_q);

  property p_read_word;
    (clk_en && reg_rd && hit) |=> (reg_rdata == $past(csts_word));
  endproperty
  a_read_word: assert property (p_read_word) else $error("read data mismatch");

  property p_read_idle;
    (clk_en && !(reg_rd && hit)) |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not zero");

  property p_a_fields_take;
    (clk_en && wr_hit && !cmp_a_freeze) |=>
      ({cmp_a_hysteresis, cmp_a_polarity_flip, cmp_a_route, cmp_a_minus_select,
        cmp_a_speed_power, cmp_a_dac_switch, cmp_a_enable}
       == {$past(reg_wdata[13:8]), $past(reg_wdata[6:0])});
  endproperty
  a_a_fields_take: assert property (p_a_fields_take) else $error("A write lost");

  property p_b_fields_take;
    (clk_en && wr_hit && !cmp_b_freeze) |=>
      ({cmp_b_hysteresis, cmp_b_polarity_flip, cmp_b_route, window_pair_enable,
        cmp_b_minus_select, cmp_b_speed_power} == $past(reg_wdata[29:18]))
      && (cmp_b_enable == $past(reg_wdata[16]));
  endproperty
  a_b_fields_take: assert property (p_b_fields_take) else $error("B write lost");

  property p_a_frozen_hold;
    cmp_a_freeze |=> $stable({cmp_a_hysteresis, cmp_a_polarity_flip, cmp_a_route,
      cmp_a_minus_select, cmp_a_speed_power, cmp_a_dac_switch, cmp_a_enable});
  endproperty
  a_a_frozen_hold: assert property (p_a_frozen_hold) else $error("A changed frozen");

  property p_b_frozen_hold;
    cmp_b_freeze |=> $stable({cmp_b_hysteresis, cmp_b_polarity_flip, cmp_b_route,
      window_pair_enable, cmp_b_minus_select, cmp_b_speed_power, cmp_b_enable});
  endproperty
  a_b_frozen_hold: assert property (p_b_frozen_hold) else $error("B changed frozen");

  property p_a_freeze_sticky;
    cmp_a_freeze |=> cmp_a_freeze [*3];
  endproperty
  a_a_freeze_sticky: assert property (p_a_freeze_sticky) else $error("A freeze fell");

  property p_b_freeze_set;
    (clk_en && wr_hit && reg_wdata[`CPR_B_FRZ]) |=> cmp_b_freeze;
  endproperty
  a_b_freeze_set: assert property (p_b_freeze_set) else $error("B freeze not set");

  property p_a_freeze_rise;
    $rose(cmp_a_freeze) |-> $past(clk_en && wr_hit && reg_wdata[`CPR_A_FRZ]);
  endproperty
  a_a_freeze_rise: assert property (p_a_freeze_rise) else $error("A freeze unasked");

  sequence s_a_steady;
    (clk_en && $stable(cmp_a_raw) && $stable(cmp_a_polarity_flip)) [*4];
  endsequence
  property p_a_level;
    s_a_steady |-> (cmp_a_level == (cmp_a_raw ^ cmp_a_polarity_flip));
  endproperty
  a_a_level: assert property (p_a_level) else $error("A level wrong");

  property p_b_sync_delay;
    (clk_en && !cmp_b_polarity_flip) [*4] |-> (cmp_b_level == $past(cmp_b_raw, 3));
  endproperty
  a_b_sync_delay: assert property (p_b_sync_delay) else $error("B sync delay");

  property p_window_tie;
    (clk_en && wr_hit && !cmp_b_freeze) |=>
      (plus_inputs_tied == $past(reg_wdata[`CPR_B_WIN])) && (cmp_b_pin_connect != plus_inputs_tied);
  endproperty
  a_window_tie: assert property (p_window_tie) else $error("window tie wrong");

  property p_reserved_zero;
    (clk_en && reg_rd) |=> (reg_rdata[`CPR_A_RSV] == 1'b0) && (reg_rdata[`CPR_B_RSV] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_a_dest;
    (clk_en && cmp_a_route == CPR_RT_NONE) |=> (cmp_a_dest == 7'h00);
  endproperty
  a_a_dest: assert property (p_a_dest) else $error("A routed to none");

  property p_a_freeze_set;
    (clk_en && wr_hit && reg_wdata[`CPR_A_FRZ]) |=> cmp_a_freeze;
  endproperty
  a_a_freeze_set: assert property (p_a_freeze_set) else $error("A freeze not set");

  property p_b_freeze_sticky;
    cmp_b_freeze |=> cmp_b_freeze [*3];
  endproperty
  a_b_freeze_sticky: assert property (p_b_freeze_sticky) else $error("B freeze fell");

  property p_b_freeze_rise;
    $rose(cmp_b_freeze) |-> $past(clk_en && wr_hit && reg_wdata[`CPR_B_FRZ]);
  endproperty
  a_b_freeze_rise: assert property (p_b_freeze_rise) else $error("B freeze unasked");

  property p_b_dest;
    (clk_en && cmp_b_route == CPR_RT_NONE) |=> (cmp_b_dest == 7'h00);
  endproperty
  a_b_dest: assert property (p_b_dest) else $error("B routed to none");

  property p_a_dest_hot;
    (clk_en && cmp_a_route != CPR_RT_NONE && cmp_a_level) |=> $onehot(cmp_a_dest);
  endproperty
  a_a_dest_hot: assert property (p_a_dest_hot) else $error("A route not one-hot");

  property p_a_sync_delay;
    (clk_en && !cmp_a_polarity_flip) [*4] |-> (cmp_a_level == $past(cmp_a_raw, 3));
  endproperty
  a_a_sync_delay: assert property (p_a_sync_delay) else $error("A sync delay");

  sequence s_b_steady;
    (clk_en && $stable(cmp_b_raw) && $stable(cmp_b_polarity_flip)) [*4];
  endsequence
  property p_b_level;
    s_b_steady |-> (cmp_b_level == (cmp_b_raw ^ cmp_b_polarity_flip));
  endproperty
  a_b_level: assert property (p_b_level) else $error("B level wrong");

  // A low enable stalls all but the reset release, read data included
  property p_rdata_frozen;
    !clk_en |=> $stable(reg_rdata);
  endproperty
  a_rdata_frozen: assert property (p_rdata_frozen) else $error("read data moved");

  property p_fields_frozen;
    !clk_en |=> $stable({cmp_a_freeze, cmp_b_freeze, cmp_a_route, cmp_b_route, cmp_a_level});
  endproperty
  a_fields_frozen: assert property (p_fields_frozen) else $error("state moved");

  c_a_freeze: cover property (clk_en && wr_hit && reg_wdata[`CPR_A_FRZ] && !cmp_a_freeze);
  c_b_freeze: cover property (clk_en && wr_hit && reg_wdata[`CPR_B_FRZ] && !cmp_b_freeze);
  c_locked_write: cover property (clk_en && wr_hit && cmp_b_freeze);
  c_window_on: cover property ($rose(window_pair_enable));
  c_read_back: cover property (clk_en && reg_rd && hit ##1 reg_rdata != 32'h0000_0000);
endmodule

// >>> rtl/cpr_lane.sv
// Control fields of one comparator with its write-once freeze
`timescale 1ns/1ps
module cpr_lane
  import cpr_pkg::*;
(
  input wire logic clk, // Peripheral clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic wr_hit, // Write strobe to the control word
  input wire logic en_in, // New enable
  input wire logic aux_in, // New extra bit (switch or window)
  input wire cpr_speed_t spd_in, // New speed/power
  input wire cpr_msel_t msel_in, // New minus input select
  input wire cpr_route_t route_in, // New output route
  input wire logic flip_in, // New polarity flip
  input wire cpr_hyst_t hys_in, // New hysteresis
  input wire logic frz_in, // Freeze request
  output logic en_q, // Enable
  output logic aux_q, // Extra bit
  output cpr_speed_t spd_q, // Speed/power
  output cpr_msel_t msel_q, // Minus input select
  output cpr_route_t route_q, // Output route
  output logic flip_q, // Polarity flip
  output cpr_hyst_t hys_q, // Hysteresis
  output logic frz_q // Freeze state
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      aux_q <= 1'b0;
      spd_q <= CPR_SPD_HIGH;
      msel_q <= CPR_MS_QUARTER;
      route_q <= CPR_RT_NONE;
      flip_q <= 1'b0;
      hys_q <= CPR_HYS_NONE;
    end else if (clk_en && wr_hit && !frz_q) begin
      en_q <= en_in;
      aux_q <= aux_in;
      spd_q <= spd_in;
      msel_q <= msel_in;
      route_q <= route_in;
      flip_q <= flip_in;
      hys_q <= hys_in;
    end
  end

  // Only a reset clears it; a write of zero has no effect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frz_q <= 1'b0;
    end else if (clk_en && wr_hit && frz_in) begin
      frz_q <= 1'b1;
    end
  end
endmodule

// >>> rtl/cpr_params.svh
// Register offset, field positions and reset value of the comparator pair bank
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH

`define CPR_CSTS_OFF 32'h0000_001c
`define CPR_CSTS_RST 32'h0000_0000

`define CPR_A_EN 0
`define CPR_A_SW 1
`define CPR_A_SPD 2
`define CPR_A_MSEL 4
`define CPR_A_RSV 7
`define CPR_A_ROUTE 8
`define CPR_A_FLIP 11
`define CPR_A_HYS 12
`define CPR_A_LVL 14
`define CPR_A_FRZ 15
`define CPR_B_EN 16
`define CPR_B_RSV 17
`define CPR_B_SPD 18
`define CPR_B_MSEL 20
`define CPR_B_WIN 23
`define CPR_B_ROUTE 24
`define CPR_B_FLIP 27
`define CPR_B_HYS 28
`define CPR_B_LVL 30
`define CPR_B_FRZ 31

`endif

// >>> rtl/cpr_pkg.sv
// Types shared by the comparator pair control bank
package cpr_pkg;
  typedef enum logic [1:0] {CPR_SPD_HIGH, CPR_SPD_MED, CPR_SPD_LOW, CPR_SPD_VLOW} cpr_speed_t;
  typedef enum logic [1:0] {CPR_HYS_NONE, CPR_HYS_LOW, CPR_HYS_MED, CPR_HYS_HIGH} cpr_hyst_t;
  typedef enum logic [2:0] {
    CPR_MS_QUARTER, CPR_MS_HALF, CPR_MS_3QUARTER, CPR_MS_FULL,
    CPR_MS_PIN4, CPR_MS_PIN5, CPR_MS_PIN6, CPR_MS_RSVD
  } cpr_msel_t;
  typedef enum logic [2:0] {
    CPR_RT_NONE, CPR_RT_T1_BRK, CPR_RT_T1_CAP1, CPR_RT_T1_OCLR,
    CPR_RT_T2_CAP4, CPR_RT_T2_OCLR, CPR_RT_T3_CAP1, CPR_RT_T3_OCLR
  } cpr_route_t;

  // One-hot timer destination, bit n-1 for route code n; none gives zero
  function automatic logic [6:0] cpr_route_onehot(input cpr_route_t r);
    logic [6:0] oh;
    oh = 7'h00;
    case (r)
      CPR_RT_NONE: oh = 7'h00;
      default: oh = 7'h01 << (3'(r) - 3'h1);
    endcase
    return oh;
  endfunction
endpackage

// >>> rtl/cpr_sync.sv
// Two-flop synchroniser for the raw comparator levels
`timescale 1ns/1ps
module cpr_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Peripheral clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic clk_en, // Freezes both stages while low
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);
  if (W < 1) begin : g_bad_w
    $error("cpr_sync: W must be at least 1");
  end

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> verification/cpr_cmp_model.sv
// Behavioural model of the two analog comparators facing the bank
`timescale 1ns/1ps
module cpr_cmp_model #(
  parameter int SETTLE_NS = 2
) (
  input wire logic a_en, // Comparator A on
  input wire logic b_en, // Comparator B on
  input wire logic tied, // Plus inputs joined
  input wire logic b_pin, // B plus input on its own pin
  input wire logic a_hi, // A plus above minus
  input wire logic b_hi, // B pin above minus
  output logic a_raw, // Raw A output
  output logic b_raw // Raw B output
);
  // A disabled comparator settles low, never holds its last level
  assign #(SETTLE_NS) a_raw = a_en & a_hi;
  assign #(SETTLE_NS) b_raw = b_en & ((tied & a_hi) | (b_pin & b_hi));
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the comparator pair control bank
`timescale 1ns/1ps
`include "cpr_params.svh"
module tb_top;
  localparam logic [7:0] OFF = 8'(`CPR_CSTS_OFF);
  logic clk, nrst, clk_en, reg_wr, reg_rd, a_hi, b_hi, a_raw, b_raw;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, sh;
  logic a_en, a_sw, a_flip, a_frz, a_lvl, b_en, b_flip, b_frz, b_lvl, win, tied, b_pin;
  logic [1:0] a_spd, a_hys, b_spd, b_hys;
  logic [2:0] a_ms, a_rt, b_ms, b_rt;
  logic [6:0] a_dst, b_dst;
  int n_mismatch, checks_done;

  cpr_ctrl_bank #(.ADDR_W(8)) uut (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_a_raw(a_raw),
    .cmp_b_raw(b_raw), .cmp_a_enable(a_en), .cmp_a_dac_switch(a_sw),
    .cmp_a_speed_power(a_spd), .cmp_a_minus_select(a_ms), .cmp_a_route(a_rt),
    .cmp_a_polarity_flip(a_flip), .cmp_a_hysteresis(a_hys), .cmp_a_freeze(a_frz),
    .cmp_a_level(a_lvl), .cmp_a_dest(a_dst), .cmp_b_enable(b_en),
    .cmp_b_speed_power(b_spd), .cmp_b_minus_select(b_ms), .cmp_b_route(b_rt),
    .cmp_b_polarity_flip(b_flip), .cmp_b_hysteresis(b_hys), .cmp_b_freeze(b_frz),
    .cmp_b_level(b_lvl), .cmp_b_dest(b_dst), .window_pair_enable(win),
    .plus_inputs_tied(tied), .cmp_b_pin_connect(b_pin)
  );

  cpr_cmp_model #(.SETTLE_NS(2)) u_cmp (
    .a_en(a_en), .b_en(b_en), .tied(tied), .b_pin(b_pin), .a_hi(a_hi), .b_hi(b_hi),
    .a_raw(a_raw), .b_raw(b_raw)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [6:0] dest(input logic [2:0] r, input logic l);
    return (l && r != 3'h0) ? 7'h01 << (r - 3'h1) : 7'h00;
  endfunction

  // Every control field gets code k, freeze bits zero; reserved and level bits written as ones
  function automatic logic [31:0] pack(input logic [2:0] k);
    return {2'b01, k[1:0], k[1], k, k[2], k, k[1:0], 1'b1, k[1], 1'b0, 1'b1, k[1:0], k[0],
            k, 1'b1, k, k[1:0], k[1], k[0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == OFF && clk_en) begin
      if (!sh[15]) sh[15:0] = d[15:0] & 16'hbf7f;
      if (!sh[31]) sh[31:16] = d[31:16] & 16'hbffd;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    sh = 32'h0;
  endtask

  task automatic settle;
    logic [31:0] d;
    logic la, lb;
    repeat (5) @(posedge clk);
    #1;
    la = (sh[0] & a_hi) ^ sh[11];
    lb = (sh[16] & (sh[23] ? a_hi : b_hi)) ^ sh[27];
    chk({16'h0, a_frz, 1'b0, a_hys, a_flip, a_rt, 1'b0, a_ms, a_spd, a_sw, a_en},
        sh & 32'h0000_bf7f);
    chk({b_frz, 1'b0, b_hys, b_flip, b_rt, win, b_ms, b_spd, 1'b0, b_en, 16'h0},
        sh & 32'hbffd_0000);
    chk({tied, b_pin, a_lvl, b_lvl}, {sh[23], !sh[23], la, lb});
    chk({a_dst, b_dst}, {dest(sh[10:8], la), dest(sh[26:24], lb)});
    rd(OFF, d);
    chk(d, sh & 32'hbffd_bf7f | {17'h0, la, 14'h0});
  endtask

  task automatic t_codes;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      a_hi <= k[2];
      b_hi <= k[0];
      wr(OFF, pack(3'(k)));
      settle;
    end
  endtask

  task automatic t_latency;
    @(posedge clk);
    a_hi <= 1'b0;
    wr(OFF, 32'h0000_0101);
    settle;
    @(posedge clk);
    a_hi <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(a_lvl, 1'b0);
    @(posedge clk);
    #1;
    chk(a_lvl, 1'b1);
    chk(a_dst, 7'h00);
    @(posedge clk);
    #1;
    chk(a_dst, 7'h01);
  endtask

  task automatic t_bus;
    logic [31:0] d;
    wr(8'h18, pack(3'h7));
    settle;
    rd(8'h20, d);
    chk(d, 32'h0);
    rd(OFF, d);
    @(posedge clk);
    #1;
    chk(reg_rdata, 32'h0);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(OFF, pack(3'h6));
    @(posedge clk);
    clk_en <= 1'b1;
    settle;
  endtask

  task automatic t_lock;
    wr(OFF, pack(3'h5) | 32'h0000_8000);
    wr(OFF, pack(3'h2));
    settle;
    wr(OFF, pack(3'h3) | 32'h8000_0000);
    wr(OFF, 32'h0);
    settle;
  endtask

  // Reset must free both lanes so they can be written and locked again
  task automatic t_reset;
    do_reset;
    settle;
    wr(OFF, pack(3'h1) | 32'h8000_8000);
    wr(OFF, pack(3'h4));
    settle;
  endtask

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    a_hi = 1'b0;
    b_hi = 1'b0;
    sh = 32'h0;
    n_mismatch = 0;
    checks_done = 0;
    do_reset;
    settle;
    t_codes;
    t_latency;
    t_bus;
    t_lock;
    t_reset;
    final_report;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end
endmodule
